// ---- common/trig_pkg.sv ----
// Shared constants and types for the burst trigger sequencer
package trig_pkg;
   localparam int SW = 16;
   localparam int CW = 16;
   localparam int NLINES = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_TRIGTOT = 8'h04;
   localparam logic [7:0] OFF_ARMTOT  = 8'h08;
   localparam logic [7:0] OFF_RECORD  = 8'h0C;
   localparam logic [7:0] OFF_PERCENT = 8'h10;
   localparam logic [7:0] OFF_HOLDOFF = 8'h14;
   localparam logic [7:0] OFF_SYNCSEL = 8'h18;
   localparam logic [7:0] OFF_REFSEL  = 8'h1C;
   localparam logic [7:0] OFF_STATUS  = 8'h20;
   localparam logic [7:0] OFF_COUNT   = 8'h24;
   // Control bit positions
   localparam int CB_INIT    = 0;
   localparam int CB_ABORT   = 1;
   localparam int CB_BURST   = 2;
   localparam int CB_INTERP  = 3;
   localparam int CB_MASTER  = 4;
   localparam int CB_BRIDGED = 5;
   localparam int CB_ARMIMM  = 6;
   // Reset values, with the percentage ceiling and divisor
   localparam logic [CW-1:0] RST_TRIGTOT = 16'h0001;
   localparam logic [CW-1:0] RST_ARMTOT  = 16'h0001;
   localparam logic [CW-1:0] RST_RECORD  = 16'h0400;
   localparam logic [6:0]    RST_PERCENT = 7'h32;
   localparam logic [6:0]    PCT_FULL    = 7'h64;
   localparam logic [22:0]   PCT_DIV     = 23'h000064;
   localparam logic [CW-1:0] RST_HOLDOFF = 16'h0000;
   localparam logic [2:0]    RST_SYNCSEL = 3'h0;
   localparam logic [1:0]    RST_REFSEL  = 2'h0;
   // Interpolation delay line depth
   localparam int TAPS = 32;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_ARM, ST_WAIT_TRIG, ST_DONE}
      seq_state_t;
endpackage

// ---- common/sample_if.sv ----
// Sample path between sequencer and interpolation stage
`timescale 1ns/1ns
`default_nettype none
interface sample_if;
   logic [15:0] raw;
   logic        bypass;
   logic [15:0] shaped;
   modport host (output raw, output bypass, input shaped);
   modport filt (input raw, input bypass, output shaped);
endinterface
`default_nettype wire

// ---- rtl/edge_pulse.sv ----
// Input synchroniser with one-cycle rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module edge_pulse #(parameter int W = 1) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] pulse
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] p;
   } ep_t;
   ep_t cur_r, nxt;

   always_comb begin
      nxt    = cur_r;
      nxt.s1 = din;
      nxt.s2 = cur_r.s1;
      nxt.s3 = cur_r.s2;
      nxt.p  = cur_r.s2 & ~cur_r.s3;
   end

   always_ff @(posedge clk) begin
      if (rst) cur_r <= '0;
      else cur_r <= nxt;
   end

   assign pulse = cur_r.p;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_pulse_single: assert property (pulse[0] |=> !pulse[0])
      else $error("edge pulse lasted more than one cycle");
endmodule // edge_pulse
`default_nettype wire

// ---- rtl/interp_delay.sv ----
// Interpolation stage adding a 32.5 sample group delay
`timescale 1ns/1ns
`default_nettype none
module interp_delay import trig_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   sample_if.filt   sp
);
   typedef struct packed {
      logic [TAPS-1:0][SW-1:0] d;
      logic [SW-1:0]           out;
   } id_t;
   id_t cur_r, nxt;
   logic [SW:0] sum;

   assign sum = {cur_r.d[TAPS-2][SW-1], cur_r.d[TAPS-2]}
              + {cur_r.d[TAPS-1][SW-1], cur_r.d[TAPS-1]};

   always_comb begin
      nxt = cur_r;
      nxt.d = {cur_r.d[TAPS-2:0], sp.raw};
      // Mean of two neighbour taps gives the half-sample step
      if (sp.bypass) nxt.out = sp.raw;
      else nxt.out = sum[SW:1];
   end

   always_ff @(posedge clk) begin
      if (rst) cur_r <= '0;
      else cur_r <= nxt;
   end

   assign sp.shaped = cur_r.out;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_interp_latency: assert property (
      !$past(sp.bypass) && !$past(rst, 34) && $past(sp.raw, 32) == 16'h0000
      && $past(sp.raw, 33) == 16'h0000 |-> sp.shaped == 16'h0000)
      else $error("interpolated sample not at 32.5 cycle latency");
endmodule // interp_delay
`default_nettype wire

// ---- rtl/burst_trigger_sequencer.sv ----
// Trigger, arm and burst sequencer with backplane coordination
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module burst_trigger_sequencer import trig_pkg::*; (
   input  wire logic              SYS_CLK,
   input  wire logic              RESET,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              CHAN_READY,
   input  wire logic              TRIG_IN,
   input  wire logic              ARM_IN,
   input  wire logic [NLINES-1:0] SYNC_LINE_IN,
   output logic      [NLINES-1:0] SYNC_LINE_OUT,
   output logic      [NLINES-1:0] SYNC_LINE_OE,
   input  wire logic [SW-1:0]     SAMPLE_IN,
   output logic      [SW-1:0]     DAC_OUT,
   output logic                   DAC_GATE,
   output logic                   REF_CLK_SEL,
   output logic                   TS_CLK_SEL
);
   typedef struct packed {
      seq_state_t        st;
      logic [31:0]       prdata;
      logic              burst_mode;
      logic              interp_en;
      logic              master;
      logic              bridged;
      logic              arm_imm;
      logic [CW-1:0]     trig_total;
      logic [CW-1:0]     arm_total;
      logic [CW-1:0]     rec_len;
      logic [6:0]        pct;
      logic [CW-1:0]     holdoff;
      logic [2:0]        line_sel;
      logic [1:0]        ref_sel;
      logic [CW-1:0]     trig_cnt;
      logic [CW-1:0]     arm_cnt;
      logic [CW-1:0]     guard;
      logic [CW-1:0]     burst_left;
      logic              cont_on;
      logic              gate;
      logic [NLINES-1:0] line_drv;
      logic [SW-1:0]     dac;
   } seq_t;

   seq_t cur_r, nxt;
   logic [2:0]    raw_in;
   logic [2:0]    ev;
   logic          trig_local;
   logic          arm_ev;
   logic          line_ev;
   logic          wr;
   logic          ctl_wr;
   logic          abort_wr;
   logic          init_wr;
   logic          hit;
   logic [31:0]   rd_val;
   logic [22:0]   prod;
   logic [22:0]   quot;
   logic [CW-1:0] on_len;
   logic [CW-1:0] gap;
   logic          can_orig;
   logic          acc;
   logic          last_trig;
   logic          last_arm;
   sample_if      sif ();

   // Selected coordination line is synchronised with the local inputs
   assign raw_in = {SYNC_LINE_IN[cur_r.line_sel], ARM_IN, TRIG_IN};

   edge_pulse #(.W(3)) u_edges (
      .clk   (SYS_CLK),
      .rst   (RESET),
      .din   (raw_in),
      .pulse (ev)
   );

   assign trig_local = ev[0];
   assign arm_ev     = ev[1];
   assign line_ev    = ev[2];

   assign sif.raw    = SAMPLE_IN;
   assign sif.bypass = ~cur_r.interp_en;

   interp_delay u_interp (
      .clk (SYS_CLK),
      .rst (RESET),
      .sp  (sif.host)
   );

   assign wr       = PSEL & PENABLE & PWRITE;
   assign ctl_wr   = wr && PADDR == OFF_CTRL;
   assign abort_wr = ctl_wr & PWDATA[CB_ABORT];
   assign init_wr  = ctl_wr & PWDATA[CB_INIT] & ~PWDATA[CB_ABORT];

   // Burst length is the percentage share of the record
   assign prod   = 23'(cur_r.rec_len) * 23'(cur_r.pct);
   assign quot   = prod / PCT_DIV;
   assign on_len = quot[CW-1:0];
   // Spacing covers both record length and holdoff
   assign gap = (cur_r.rec_len > cur_r.holdoff) ? cur_r.rec_len
                                                : cur_r.holdoff;

   // Bridged links run one way: only the master segment may originate
   assign can_orig = cur_r.master | ~cur_r.bridged;

   // Every card acts on the shared line; an event in holdoff or with the channel not ready is ignored
   assign acc = cur_r.st == ST_WAIT_TRIG && line_ev
             && cur_r.guard == '0
             && CHAN_READY;
   assign last_trig = cur_r.trig_cnt + 16'h0001 == cur_r.trig_total;
   assign last_arm  = cur_r.arm_total != '0
                   && cur_r.arm_cnt + 16'h0001 == cur_r.arm_total;

   always_comb begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      case (PADDR)
         OFF_CTRL:    rd_val[6:2] = {cur_r.arm_imm, cur_r.bridged,
                                     cur_r.master, cur_r.interp_en,
                                     cur_r.burst_mode};
         OFF_TRIGTOT: rd_val[CW-1:0] = cur_r.trig_total;
         OFF_ARMTOT:  rd_val[CW-1:0] = cur_r.arm_total;
         OFF_RECORD:  rd_val[CW-1:0] = cur_r.rec_len;
         OFF_PERCENT: rd_val[6:0] = cur_r.pct;
         OFF_HOLDOFF: rd_val[CW-1:0] = cur_r.holdoff;
         OFF_SYNCSEL: rd_val[2:0] = cur_r.line_sel;
         OFF_REFSEL:  rd_val[1:0] = cur_r.ref_sel;
         OFF_STATUS:  rd_val[3:0] = {CHAN_READY, cur_r.gate, cur_r.st};
         OFF_COUNT:   rd_val = {cur_r.arm_cnt, cur_r.trig_cnt};
         default:     hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt = cur_r;
      if (PSEL && !PENABLE && !PWRITE) nxt.prdata = rd_val;
      if (wr) begin
         case (PADDR)
            OFF_CTRL: begin
               nxt.burst_mode = PWDATA[CB_BURST];
               nxt.interp_en  = PWDATA[CB_INTERP];
               nxt.master     = PWDATA[CB_MASTER];
               nxt.bridged    = PWDATA[CB_BRIDGED];
               nxt.arm_imm    = PWDATA[CB_ARMIMM];
            end
            OFF_TRIGTOT: nxt.trig_total = PWDATA[CW-1:0];
            OFF_ARMTOT:  nxt.arm_total = PWDATA[CW-1:0];
            OFF_RECORD:  nxt.rec_len = PWDATA[CW-1:0];
            OFF_PERCENT: nxt.pct = (PWDATA[6:0] > PCT_FULL) ? PCT_FULL
                                                            : PWDATA[6:0];
            OFF_HOLDOFF: nxt.holdoff = PWDATA[CW-1:0];
            OFF_SYNCSEL: nxt.line_sel = PWDATA[2:0];
            OFF_REFSEL:  nxt.ref_sel = PWDATA[1:0];
            default: ;
         endcase
      end

      if (cur_r.guard != '0) nxt.guard = cur_r.guard - 16'h0001;
      if (cur_r.burst_left != '0)
         nxt.burst_left = cur_r.burst_left - 16'h0001;

      // Local edge goes out on the line for one cycle
      nxt.line_drv = '0;
      if (trig_local && can_orig && cur_r.st != ST_IDLE)
         nxt.line_drv = 8'h01 << cur_r.line_sel;

      case (cur_r.st)
         ST_IDLE, ST_DONE: begin
            if (init_wr) begin
               nxt.st       = ST_WAIT_ARM;
               nxt.trig_cnt = '0;
               nxt.arm_cnt  = '0;
               nxt.guard    = '0;
            end
         end
         ST_WAIT_ARM: begin
            if (arm_ev || cur_r.arm_imm) nxt.st = ST_WAIT_TRIG;
         end
         ST_WAIT_TRIG: begin
            if (acc) begin
               // Start in the cycle after the accepted trigger; no further delay is applied
               if (cur_r.burst_mode) nxt.burst_left = on_len;
               else nxt.cont_on = 1'b1;
               nxt.guard = (gap == '0) ? '0 : gap - 16'h0001;
               nxt.trig_cnt = cur_r.trig_cnt + 16'h0001;
               if (last_trig) begin
                  nxt.trig_cnt = '0;
                  nxt.arm_cnt  = cur_r.arm_cnt + 16'h0001;
                  nxt.st = last_arm ? ST_DONE : ST_WAIT_ARM;
               end
            end
         end
         default: nxt.st = ST_IDLE;
      endcase

      if (abort_wr) begin
         nxt.st         = ST_IDLE;
         nxt.burst_left = '0;
         nxt.cont_on    = 1'b0;
         nxt.guard      = '0;
      end

      nxt.gate = nxt.burst_left != '0 || nxt.cont_on;
      nxt.dac  = cur_r.gate ? sif.shaped : 16'h0000;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         cur_r            <= '0;
         cur_r.st         <= ST_IDLE;
         cur_r.trig_total <= RST_TRIGTOT;
         cur_r.arm_total  <= RST_ARMTOT;
         cur_r.rec_len    <= RST_RECORD;
         cur_r.pct        <= RST_PERCENT;
         cur_r.holdoff    <= RST_HOLDOFF;
         cur_r.line_sel   <= RST_SYNCSEL;
         cur_r.ref_sel    <= RST_REFSEL;
      end else begin
         cur_r <= nxt;
      end
   end

   assign PRDATA        = cur_r.prdata;
   assign PREADY        = 1'b1;
   assign PSLVERR       = PSEL & PENABLE & ~hit;
   assign SYNC_LINE_OUT = cur_r.line_drv;
   assign SYNC_LINE_OE  = cur_r.line_drv;
   assign DAC_OUT       = cur_r.dac;
   assign DAC_GATE      = cur_r.gate;
   assign REF_CLK_SEL   = cur_r.ref_sel[0];
   assign TS_CLK_SEL    = cur_r.ref_sel[1];

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   sequence s_accept_burst3;
      acc && cur_r.burst_mode && on_len == 16'h0003 && !cur_r.cont_on
      && !abort_wr;
   endsequence
   sequence s_gate3;
      DAC_GATE [*3] ##1 !DAC_GATE;
   endsequence

   a_start_ready: assert property (
      $rose(DAC_GATE) |-> $past(CHAN_READY))
      else $error("output started while channel not ready");
   a_start_now: assert property (
      acc && !abort_wr && (!cur_r.burst_mode || on_len != '0) |=> DAC_GATE)
      else $error("output did not start in cycle after trigger");
   a_count_done: assert property (
      acc && last_trig && !abort_wr |=> cur_r.st != ST_WAIT_TRIG
      && cur_r.trig_cnt == '0)
      else $error("trigger total reached but still waiting for trigger");
   a_burst_load: assert property (
      acc && cur_r.burst_mode && !abort_wr
      |=> cur_r.burst_left == $past(on_len))
      else $error("burst not loaded on accepted trigger");
   a_holdoff_drop: assert property (
      line_ev && cur_r.guard != '0 && !ctl_wr
      |=> $stable(cur_r.trig_cnt) && $stable(cur_r.arm_cnt))
      else $error("trigger inside holdoff was counted");
   a_burst_length: assert property (
      s_accept_burst3 |=> s_gate3)
      else $error("burst length differs from programmed share");
   a_spacing: assert property (
      acc && !abort_wr && gap != '0 |=> cur_r.guard == $past(gap) - 16'h0001)
      else $error("spacing guard not set to record or holdoff");
   a_ref_select: assert property (
      wr && PADDR == OFF_REFSEL |=> REF_CLK_SEL == $past(PWDATA[0])
      && TS_CLK_SEL == $past(PWDATA[1]))
      else $error("reference select not applied");
   a_line_drive: assert property (
      trig_local && can_orig && cur_r.st != ST_IDLE
      |=> SYNC_LINE_OE == (8'h01 << $past(cur_r.line_sel)))
      else $error("coordination line not driven on local trigger");
   a_line_follow: assert property (
      $rose(DAC_GATE) |-> $past(line_ev))
      else $error("output started without coordination line event");
   a_bridged_quiet: assert property (
      !can_orig |=> SYNC_LINE_OE == '0)
      else $error("slave segment card originated a trigger");
   a_arm_forever: assert property (
      cur_r.arm_total == '0 && cur_r.st != ST_DONE && !abort_wr
      |=> cur_r.st != ST_DONE)
      else $error("measurement finished with arm total zero");
   a_unready_ignored: assert property (
      line_ev && !CHAN_READY && !ctl_wr
      |=> $stable(cur_r.trig_cnt) && !$rose(DAC_GATE))
      else $error("trigger while not ready started or counted");
endmodule // burst_trigger_sequencer
`default_nettype wire

// ---- dv/peer_cards.sv ----
// Peer cards sharing the backplane trigger lines with the block
`timescale 1ns/1ns
`default_nettype none
module peer_cards import trig_pkg::*; (
   input  wire logic              clk,
   input  wire logic [NLINES-1:0] dut_out,
   input  wire logic [NLINES-1:0] dut_oe,
   input  wire logic              fire,
   input  wire logic [2:0]        sel,
   input  wire logic [3:0]        lat,
   output logic      [NLINES-1:0] line
);
   logic [NLINES-1:0] drv = '0;
   int                cnt = -1;
   // Peer trigger goes out after its own engine latency
   always @(posedge clk) begin
      drv <= '0;
      if (fire)
         cnt <= lat;
      else if (cnt >= 0)
         cnt <= cnt - 1;
      if (cnt == 0)
         drv[sel] <= 1'b1;
   end
   // Pull-down: an undriven line idles low
   assign line = (dut_oe & dut_out) | drv;
endmodule // peer_cards
`default_nettype wire

// ---- dv/burst_trigger_sequencer_tb.sv ----
// Self-checking bench for the burst trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module burst_trigger_sequencer_tb import trig_pkg::*;;
   localparam int CTL = (1 << CB_BURST) | (1 << CB_MASTER) | (1 << CB_ARMIMM);
   localparam logic [7:0] RA [0:9] = '{OFF_CTRL, OFF_TRIGTOT, OFF_ARMTOT,
      OFF_RECORD, OFF_PERCENT, OFF_HOLDOFF, OFF_SYNCSEL, OFF_REFSEL,
      OFF_STATUS, 8'h28};
   localparam logic [31:0] RV [0:9] = '{32'h0, 32'(RST_TRIGTOT),
      32'(RST_ARMTOT), 32'(RST_RECORD), 32'(RST_PERCENT),
      32'(RST_HOLDOFF), 32'(RST_SYNCSEL), 32'(RST_REFSEL), 32'h8, 32'h0};
   logic              SYS_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY;
   logic              PSLVERR, CHAN_READY, TRIG_IN, ARM_IN, err, pf;
   logic              DAC_GATE, REF_CLK_SEL, TS_CLK_SEL, hold;
   logic [7:0]        PADDR;
   logic [31:0]       PWDATA, PRDATA, rd, seed;
   logic [NLINES-1:0] lin, lout, loe;
   logic [SW-1:0]     SAMPLE_IN, DAC_OUT, hv;
   logic [2:0]        ps;
   logic [3:0]        pl;
   int                n_mismatch, checked, cyc, m_cnt, m_len, m_gap;

   burst_trigger_sequencer i_dut (.SYS_CLK(SYS_CLK), .RESET(RESET),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .CHAN_READY(CHAN_READY), .TRIG_IN(TRIG_IN),
      .ARM_IN(ARM_IN), .SYNC_LINE_IN(lin), .SYNC_LINE_OUT(lout),
      .SYNC_LINE_OE(loe), .SAMPLE_IN(SAMPLE_IN), .DAC_OUT(DAC_OUT),
      .DAC_GATE(DAC_GATE), .REF_CLK_SEL(REF_CLK_SEL),
      .TS_CLK_SEL(TS_CLK_SEL));
   peer_cards i_peer (.clk(SYS_CLK), .dut_out(lout), .dut_oe(loe),
      .fire(pf), .sel(ps), .lat(pl), .line(lin));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic wrap_up;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge SYS_CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // Idle edge keeps the next setup off this release
      @(posedge SYS_CLK);
   endtask

   // Peer trigger, then measure the burst it should or should not start
   task automatic shot(input int l, input logic acc);
      int n;
      ps <= l[2:0];
      pf <= 1'b1;
      @(posedge SYS_CLK);
      pf <= 1'b0;
      n = 0;
      while (DAC_GATE !== 1'b1 && n < 16) begin
         @(posedge SYS_CLK);
         n++;
      end
      n = 0;
      while (DAC_GATE === 1'b1 && n < 400) begin
         @(posedge SYS_CLK);
         n++;
      end
      chk(n, acc ? m_len : 0);
      if (acc && m_cnt >= 0)
         m_cnt++;
      repeat (m_gap) @(posedge SYS_CLK);
      apb(1'b0, OFF_COUNT, 32'h0);
      if (m_cnt >= 0)
         chk(rd[15:0], m_cnt[15:0]);
   endtask

   task automatic ltrig(input int e);
      int n;
      n = 0;
      TRIG_IN <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      TRIG_IN <= 1'b0;
      repeat (12) begin
         @(posedge SYS_CLK);
         n += int'(loe[ps] === 1'b1 && lout === loe);
      end
      chk(n, e);
      m_cnt += e;
      repeat (40) @(posedge SYS_CLK);
   endtask

   task automatic arm;
      ARM_IN <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      ARM_IN <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
   endtask

   always #5 SYS_CLK = ~SYS_CLK;

   always @(posedge SYS_CLK) begin
      seed <= nxt(seed);
      SAMPLE_IN <= hold ? hv : seed[15:0];
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         wrap_up;
      end
   end

   initial begin
      SYS_CLK = 1'b0;
      RESET = 1'b1;
      {PSEL, PENABLE, PWRITE, TRIG_IN, ARM_IN, pf, hold} = '0;
      {PADDR, PWDATA, SAMPLE_IN, hv, ps, pl} = '0;
      CHAN_READY = 1'b1;
      seed = 32'h4E4ACD8C;
      repeat (20) @(posedge SYS_CLK);
      RESET <= 1'b0;
      @(posedge SYS_CLK);
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, RA[i], 32'h0);
         chk(rd, RV[i]);
         chk(err, i == 9);
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFF_REFSEL, i);
         repeat (2) @(posedge SYS_CLK);
         chk({TS_CLK_SEL, REF_CLK_SEL}, i);
      end
      apb(1'b1, OFF_PERCENT, 32'hFF);
      apb(1'b0, OFF_PERCENT, 32'h0);
      chk(rd, PCT_FULL);
      apb(1'b1, OFF_TRIGTOT, 100);
      apb(1'b1, OFF_CTRL, CTL | 1 << CB_INIT);
      m_len = 10;
      m_cnt = 0;
      for (int h = 0; h < 2; h++) begin
         // Holdoff rules first, then record length; burst stays 10
         apb(1'b1, OFF_HOLDOFF, h ? 5 : 30);
         apb(1'b1, OFF_RECORD, h ? 40 : 20);
         apb(1'b1, OFF_PERCENT, h ? 25 : 50);
         pl <= 4'(h * 6);
         m_gap = 0;
         shot(0, 1'b1);
         m_gap = 20;
         shot(0, 1'b0);
         shot(0, 1'b1);
      end
      CHAN_READY <= 1'b0;
      shot(0, 1'b0);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd[3:0], 4'h2);
      CHAN_READY <= 1'b1;
      for (int l = 0; l < NLINES; l++) begin
         apb(1'b1, OFF_SYNCSEL, l);
         shot((l + 1) % NLINES, 1'b0);
         shot(l, 1'b1);
      end
      apb(1'b1, OFF_CTRL, CTL & ~(1 << CB_MASTER) | 1 << CB_BRIDGED);
      ltrig(0);
      apb(1'b1, OFF_CTRL, CTL | 1 << CB_BRIDGED);
      ltrig(1);
      apb(1'b1, OFF_CTRL, CTL & ~(1 << CB_MASTER));
      ltrig(1);
      shot(7, 1'b1);
      m_cnt = -1;
      apb(1'b1, OFF_CTRL, 1 << CB_ABORT);
      apb(1'b1, OFF_TRIGTOT, 2);
      apb(1'b1, OFF_ARMTOT, 2);
      apb(1'b1, OFF_CTRL, CTL & ~(1 << CB_ARMIMM) | 1 << CB_INIT);
      shot(7, 1'b0);
      for (int a = 0; a < 2; a++) begin
         arm();
         shot(7, 1'b1);
         shot(7, 1'b1);
         apb(1'b0, OFF_STATUS, 32'h0);
         chk(rd[1:0], a ? 2'h3 : 2'h1);
      end
      apb(1'b1, OFF_ARMTOT, 0);
      apb(1'b1, OFF_CTRL, CTL | 1 << CB_INIT);
      repeat (6) shot(7, 1'b1);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd[1:0], 2'h2);
      // Three-cycle burst: half of a six-cycle record
      m_len = 3;
      apb(1'b1, OFF_RECORD, 6);
      apb(1'b1, OFF_PERCENT, 50);
      shot(7, 1'b1);
      hv <= 16'h1234;
      hold <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, OFF_CTRL, 1 << CB_ABORT);
         apb(1'b1, OFF_CTRL, (CTL & ~(1 << CB_BURST)) | 1 << CB_INIT
             | (k ? 0 : 1 << CB_INTERP));
         pf <= 1'b1;
         @(posedge SYS_CLK);
         pf <= 1'b0;
         repeat (50) @(posedge SYS_CLK);
         chk(DAC_OUT, 16'h1234);
         hv <= 16'hC3A5;
         repeat (20) @(posedge SYS_CLK);
         chk(DAC_OUT, k ? 16'hC3A5 : 16'h1234);
         repeat (20) @(posedge SYS_CLK);
         chk({DAC_GATE, DAC_OUT}, 17'h1C3A5);
         hv <= 16'h1234;
      end
      apb(1'b1, OFF_CTRL, 1 << CB_ABORT);
      repeat (4) @(posedge SYS_CLK);
      chk({DAC_GATE, DAC_OUT}, 17'h0);
      wrap_up();
   end
endmodule // burst_trigger_sequencer_tb
`default_nettype wire
